// File: rtl/addr_map_defines.vh
`ifndef ADDR_MAP_DEFINES_VH
`define ADDR_MAP_DEFINES_VH

// ******************************
// address space bounds
// ******************************
`define ADDR_W 16
`define IO_LO 16'h0000
`define IO_HI 16'h003F
`define RAM_LO 16'h0040
`define RAM_HI 16'h023F
`define UNIMP_A_LO 16'h0240
`define UNIMP_A_HI 16'h0FFF
`define JUMP_LO 16'h1000
`define JUMP_HI 16'h101F
`define ROUT_A_LO 16'h1020
`define ROUT_A_HI 16'h121F
`define UNIMP_B_LO 16'h1220
`define UNIMP_B_HI 16'h137D
`define ROUT_B_LO 16'h137E
`define ROUT_B_HI 16'h13FF
`define UNIMP_C_LO 16'h1400
`define UNIMP_C_HI 16'hBFFF
`define FLASH_LO 16'hC000
`define FLASH_HI 16'hFDFF
`define EXT_SEC_ADDR 16'hFDFF
`define SYS_LO 16'hFE00
`define SYS_HI 16'hFE1F
`define SYS_BRK_ADDR 16'hFE00
`define RST_CAUSE_ADDR 16'hFE01
`define BRK_FLAG_ADDR 16'hFE03
`define IRQ1_ADDR 16'hFE04
`define IRQ2_ADDR 16'hFE05
`define IRQ3_ADDR 16'hFE06
`define FL_CTRL_ADDR 16'hFE08
`define BRK_H_ADDR 16'hFE09
`define BRK_L_ADDR 16'hFE0A
`define BRK_CS_ADDR 16'hFE0B
`define LVS_ADDR 16'hFE0C
`define RSV_A 16'hFE02
`define RSV_B 16'hFE07
`define RSV_C_LO 16'hFE0D
`define RSV_C_HI 16'hFE1F
`define MON_LO 16'hFE20
`define MON_HI 16'hFF7D
`define PROT_ADDR 16'hFF7E
`define UNIMP_D 16'hFF7F
`define TRIM5_ADDR 16'hFF80
`define TRIM3_ADDR 16'hFF81
`define UNIMP_E_LO 16'hFF82
`define UNIMP_E_HI 16'hFFDB
`define VEC_LO 16'hFFDC
`define VEC_HI 16'hFFFF
`define SEC_LO 16'hFFF6
`define SEC_HI 16'hFFFD

// ******************************
// high-page register select indices
// ******************************
`define REG_N 14
`define R_SYS_BRK 0
`define R_RST_CAUSE 1
`define R_BRK_FLAG 2
`define R_IRQ1 3
`define R_IRQ2 4
`define R_IRQ3 5
`define R_FL_CTRL 6
`define R_BRK_H 7
`define R_BRK_L 8
`define R_BRK_CS 9
`define R_LVS 10
`define R_PROT 11
`define R_TRIM5 12
`define R_TRIM3 13

// ******************************
// region codes
// ******************************
`define RG_W 4
`define RG_IO 4'h0
`define RG_RAM 4'h1
`define RG_JUMP 4'h2
`define RG_ROUT 4'h3
`define RG_FLASH 4'h4
`define RG_SYSREG 4'h5
`define RG_MON 4'h6
`define RG_VEC 4'h7
`define RG_RSV 4'h8
`define RG_UNIMP 4'h9

`endif

// File: rtl/range_match.v
`timescale 1ns/1ps
`default_nettype none
// inclusive window compare on one address
module range_match #(
  parameter W = 16,
  parameter [W-1:0] LO = {W{1'b0}},
  parameter [W-1:0] HI = {W{1'b0}}
) (
  input wire [W-1:0] addr, // address under test
  output wire hit // address within window
);
  assign hit = (addr >= LO) && (addr <= HI);
endmodule // range_match
`default_nettype wire

// File: rtl/sysreg_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "addr_map_defines.vh"
// one-hot selects for the registers scattered in the high page
module sysreg_decode (
  input wire [`ADDR_W-1:0] addr, // current address
  output reg [`REG_N-1:0] sel // one-hot register select
);
  always @* begin
    sel = {`REG_N{1'b0}};
    case (addr)
      `SYS_BRK_ADDR: sel[`R_SYS_BRK] = 1'b1;
      `RST_CAUSE_ADDR: sel[`R_RST_CAUSE] = 1'b1;
      `BRK_FLAG_ADDR: sel[`R_BRK_FLAG] = 1'b1;
      `IRQ1_ADDR: sel[`R_IRQ1] = 1'b1;
      `IRQ2_ADDR: sel[`R_IRQ2] = 1'b1;
      `IRQ3_ADDR: sel[`R_IRQ3] = 1'b1;
      `FL_CTRL_ADDR: sel[`R_FL_CTRL] = 1'b1;
      `BRK_H_ADDR: sel[`R_BRK_H] = 1'b1;
      `BRK_L_ADDR: sel[`R_BRK_L] = 1'b1;
      `BRK_CS_ADDR: sel[`R_BRK_CS] = 1'b1;
      `LVS_ADDR: sel[`R_LVS] = 1'b1;
      `PROT_ADDR: sel[`R_PROT] = 1'b1;
      `TRIM5_ADDR: sel[`R_TRIM5] = 1'b1;
      `TRIM3_ADDR: sel[`R_TRIM3] = 1'b1;
      default: sel = {`REG_N{1'b0}};
    endcase
  end
endmodule // sysreg_decode
`default_nettype wire

// File: rtl/memory_map_address_decoder.v
// Notes on behaviour
// - every one of the 64 Kbyte 16-bit addresses falls in exactly one region.
// - $0000-$003F selects the 64-byte zero-page register block.
// - $0040-$023F selects the 512-byte RAM.
// - $C000-$FDFF selects user flash, with its top byte marked as extended security.
// - the unimplemented ranges raise a flag for the illegal address reset.
// - $1000-$101F is the jump table and $1020-$121F, $137E-$13FF the routine rom.
// - $FE20-$FF7D selects the monitor rom.
// - $FE00, $FE01 and $FE03 select the break status, reset cause and break flag registers.
// - $FE04-$FE06 select the three interrupt status registers.
// - $FE08-$FE0C select flash control, breakpoint high, low, control and low-voltage status.
// - $FF7E selects flash protection and $FF80, $FF81 the two oscillator trim bytes.
// - $FFDC-$FFFF selects the 36-byte vector flash.
// - $FFF6-$FFFD are flagged as the eight security bytes.
`timescale 1ns/1ps
`default_nettype none
`include "addr_map_defines.vh"
module memory_map_address_decoder #(
  parameter AW = `ADDR_W
) (
  input wire mclk, // bus clock
  input wire sys_rst, // synchronous reset, active high
  input wire clk_en, // freezes registered state while low, unless sys_rst is high
  input wire [AW-1:0] addr, // address from the processor core
  input wire access, // a bus access is in progress this cycle
  output wire sel_io, // zero-page register block
  output wire sel_ram, // ram array
  output wire sel_jump, // flash routine jump table
  output wire sel_routine, // integrated flash routine rom
  output wire sel_flash, // user flash
  output wire sel_sysreg, // high-page register area
  output wire sel_monitor, // monitor rom
  output wire sel_vector, // vector flash
  output wire sel_reserved, // reserved location
  output wire sel_unimp, // unimplemented location
  output wire ext_security, // extended security byte
  output wire security_byte, // monitor-entry security byte
  output wire system_break_status, // register select
  output wire reset_cause_status, // register select
  output wire break_flag_control, // register select
  output wire irq_status_first, // register select
  output wire irq_status_second, // register select
  output wire irq_status_third, // register select
  output wire flash_program_control, // register select
  output wire breakpoint_addr_high, // register select
  output wire breakpoint_addr_low, // register select
  output wire breakpoint_control_status, // register select
  output wire low_voltage_status, // register select
  output wire flash_protect_boundary, // register select
  output wire osc_trim_high_supply, // register select
  output wire osc_trim_low_supply, // register select
  output wire illegal_access, // unimplemented access in progress
  output reg illegal_addr_rst_q, // registered illegal address reset request
  output reg [AW-1:0] illegal_addr_q, // address of last illegal access
  output reg [`RG_W-1:0] region_q // region code of last access
);

  // ******************************
  // window hits
  // ******************************
  wire h_io, h_ram, h_jump, h_ra, h_rb, h_flash, h_mon, h_vec, h_sec, h_rsvc, h_unie;
  wire [`REG_N-1:0] reg_sel;

  range_match #(.W(AW), .LO(`IO_LO), .HI(`IO_HI)) u_io (.addr(addr), .hit(h_io));
  range_match #(.W(AW), .LO(`RAM_LO), .HI(`RAM_HI)) u_ram (.addr(addr), .hit(h_ram));
  range_match #(.W(AW), .LO(`JUMP_LO), .HI(`JUMP_HI)) u_jmp (.addr(addr), .hit(h_jump));
  range_match #(.W(AW), .LO(`ROUT_A_LO), .HI(`ROUT_A_HI)) u_ra (.addr(addr), .hit(h_ra));
  range_match #(.W(AW), .LO(`ROUT_B_LO), .HI(`ROUT_B_HI)) u_rb (.addr(addr), .hit(h_rb));
  range_match #(.W(AW), .LO(`FLASH_LO), .HI(`FLASH_HI)) u_fl (.addr(addr), .hit(h_flash));
  range_match #(.W(AW), .LO(`MON_LO), .HI(`MON_HI)) u_mon (.addr(addr), .hit(h_mon));
  range_match #(.W(AW), .LO(`VEC_LO), .HI(`VEC_HI)) u_vec (.addr(addr), .hit(h_vec));
  range_match #(.W(AW), .LO(`SEC_LO), .HI(`SEC_HI)) u_sec (.addr(addr), .hit(h_sec));
  range_match #(.W(AW), .LO(`RSV_C_LO), .HI(`RSV_C_HI)) u_rsv (.addr(addr), .hit(h_rsvc));
  range_match #(.W(AW), .LO(`UNIMP_E_LO), .HI(`UNIMP_E_HI)) u_ue (.addr(addr), .hit(h_unie));

  sysreg_decode u_regs (
    .addr(addr),
    .sel(reg_sel)
  );

  // ******************************
  // region selects
  // ******************************
  assign sel_io = h_io;
  assign sel_ram = h_ram;
  assign sel_jump = h_jump;
  assign sel_routine = h_ra | h_rb;
  assign sel_flash = h_flash;
  assign ext_security = (addr == `EXT_SEC_ADDR);
  assign sel_monitor = h_mon;
  assign sel_vector = h_vec;
  assign security_byte = h_sec;

  // reserved locations are selected so nothing else answers; the processor must not use them
  assign sel_reserved = (addr == `RSV_A) | (addr == `RSV_B) | h_rsvc;
  assign sel_sysreg = |reg_sel;

  // unimplemented is the remainder, so exactly one region always holds
  assign sel_unimp = ~(h_io | h_ram | h_jump | h_ra | h_rb | h_flash | h_mon | h_vec |
    sel_reserved | sel_sysreg);

  // ******************************
  // register selects
  // ******************************
  assign system_break_status = reg_sel[`R_SYS_BRK];
  assign reset_cause_status = reg_sel[`R_RST_CAUSE];
  assign break_flag_control = reg_sel[`R_BRK_FLAG];
  assign irq_status_first = reg_sel[`R_IRQ1];
  assign irq_status_second = reg_sel[`R_IRQ2];
  assign irq_status_third = reg_sel[`R_IRQ3];
  assign flash_program_control = reg_sel[`R_FL_CTRL];
  assign breakpoint_addr_high = reg_sel[`R_BRK_H];
  assign breakpoint_addr_low = reg_sel[`R_BRK_L];
  assign breakpoint_control_status = reg_sel[`R_BRK_CS];
  assign low_voltage_status = reg_sel[`R_LVS];
  assign flash_protect_boundary = reg_sel[`R_PROT];
  assign osc_trim_high_supply = reg_sel[`R_TRIM5];
  assign osc_trim_low_supply = reg_sel[`R_TRIM3];

  // ******************************
  // illegal access flag
  // ******************************
  // idle address lines must not raise a reset
  assign illegal_access = access & sel_unimp;

  reg [`RG_W-1:0] region_d;

  always @* begin
    if (sel_io) begin
      region_d = `RG_IO;
    end else if (sel_ram) begin
      region_d = `RG_RAM;
    end else if (sel_jump) begin
      region_d = `RG_JUMP;
    end else if (sel_routine) begin
      region_d = `RG_ROUT;
    end else if (sel_flash) begin
      region_d = `RG_FLASH;
    end else if (sel_sysreg) begin
      region_d = `RG_SYSREG;
    end else if (sel_monitor) begin
      region_d = `RG_MON;
    end else if (sel_vector) begin
      region_d = `RG_VEC;
    end else if (sel_reserved) begin
      region_d = `RG_RSV;
    end else begin
      region_d = `RG_UNIMP;
    end
  end

  // registered copies give the reset logic a clean, glitch-free request
  always @(posedge mclk) begin
    if (sys_rst) begin
      illegal_addr_rst_q <= 1'b0;
      illegal_addr_q <= {AW{1'b0}};
      region_q <= `RG_IO;
    end else if (clk_en) begin
      illegal_addr_rst_q <= illegal_access;
      if (illegal_access) begin
        illegal_addr_q <= addr;
      end
      if (access) begin
        region_q <= region_d;
      end
    end
  end

endmodule // memory_map_address_decoder
`default_nettype wire

// File: verif/core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// processor core stand-in
// ****************
module core_model (
  input wire logic mclk, // bus clock
  input wire logic [15:0] req_addr, // next address
  input wire logic req_acc, // access wanted
  output logic [15:0] addr = 16'h0000, // address to decoder
  output logic access = 1'b0 // access strobe
);
  wire rsv = req_addr == 16'hFE02 || req_addr == 16'hFE07 ||
    (req_addr >= 16'hFE0D && req_addr <= 16'hFE1F);
  // the core may sit on a reserved place but never accesses it
  always @(posedge mclk) begin
    addr <= req_addr;
    access <= req_acc && !rsv;
  end
endmodule // core_model
`default_nettype wire

// File: verif/addr_map_props.sv
`timescale 1ns/1ps
`default_nettype none
module addr_map_props #(parameter AW = 16) (
  input wire logic mclk, // bus clock
  input wire logic sys_rst, // synchronous reset
  input wire logic clk_en, // clock enable
  input wire logic access, // bus access strobe
  input wire logic [AW-1:0] addr, // address
  input wire logic sel_io, // select
  input wire logic sel_ram, // select
  input wire logic sel_jump, // select
  input wire logic sel_routine, // select
  input wire logic sel_flash, // select
  input wire logic sel_sysreg, // select
  input wire logic sel_monitor, // select
  input wire logic sel_vector, // select
  input wire logic sel_reserved, // select
  input wire logic sel_unimp, // select
  input wire logic ext_security, // flag
  input wire logic security_byte, // flag
  input wire logic system_break_status, // register select
  input wire logic irq_status_third, // register select
  input wire logic low_voltage_status, // register select
  input wire logic illegal_access, // live illegal flag
  input wire logic illegal_addr_rst_q, // registered request
  input wire logic [AW-1:0] illegal_addr_q, // registered address
  input wire logic [3:0] region_q // registered region
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_latch;
    ##1 illegal_addr_rst_q && illegal_addr_q == $past(addr);
  endsequence
  a_region_onehot: assert property ($onehot({sel_io, sel_ram, sel_jump, sel_routine,
    sel_flash, sel_sysreg, sel_monitor, sel_vector, sel_reserved, sel_unimp}))
    else $error("region selects not one-hot");
  a_io_window: assert property (sel_io == (addr <= 16'h003F))
    else $error("zero page select wrong");
  a_ram_window: assert property (sel_ram == (addr >= 16'h0040 && addr <= 16'h023F))
    else $error("ram select wrong");
  a_flash_window: assert property (sel_flash == (addr >= 16'hC000 && addr <= 16'hFDFF) &&
    ext_security == (addr == 16'hFDFF)) else $error("flash select wrong");
  a_unimp_window: assert property (sel_unimp == ((addr >= 16'h0240 && addr <= 16'h0FFF) ||
    (addr >= 16'h1220 && addr <= 16'h137D) || (addr >= 16'h1400 && addr <= 16'hBFFF) ||
    addr == 16'hFF7F || (addr >= 16'hFF82 && addr <= 16'hFFDB))) else $error("unimp wrong");
  a_reg_selects: assert property (system_break_status == (addr == 16'hFE00) &&
    irq_status_third == (addr == 16'hFE06) && low_voltage_status == (addr == 16'hFE0C))
    else $error("register select wrong");
  a_vector_window: assert property (sel_vector == (addr >= 16'hFFDC))
    else $error("vector select wrong");
  a_security_bytes: assert property (security_byte == (addr >= 16'hFFF6 && addr <= 16'hFFFD))
    else $error("security byte flag wrong");
  a_illegal_live: assert property (illegal_access == (access && sel_unimp))
    else $error("illegal flag without live access");
  // sampled reset in the antecedent: the edge that releases reset still clears the registers
  a_unimp_latch: assert property (illegal_access && clk_en && !sys_rst |-> s_latch)
    else $error("illegal access not latched");
  a_hold_frozen: assert property (!clk_en && !sys_rst |=> $stable(region_q) &&
    $stable(illegal_addr_q) && $stable(illegal_addr_rst_q))
    else $error("registers moved while frozen");
endmodule // addr_map_props
bind memory_map_address_decoder addr_map_props #(.AW(AW)) u_props (.mclk(mclk),
  .sys_rst(sys_rst), .clk_en(clk_en), .access(access), .addr(addr), .sel_io(sel_io),
  .sel_ram(sel_ram), .sel_jump(sel_jump), .sel_routine(sel_routine), .sel_flash(sel_flash),
  .sel_sysreg(sel_sysreg), .sel_monitor(sel_monitor), .sel_vector(sel_vector),
  .sel_reserved(sel_reserved), .sel_unimp(sel_unimp), .ext_security(ext_security),
  .security_byte(security_byte), .system_break_status(system_break_status),
  .irq_status_third(irq_status_third), .low_voltage_status(low_voltage_status),
  .illegal_access(illegal_access), .illegal_addr_rst_q(illegal_addr_rst_q),
  .illegal_addr_q(illegal_addr_q), .region_q(region_q));
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, req_acc = 1'b0, run = 1'b0;
  logic [15:0] req_addr = 16'h0000, edges [0:16];
  wire [15:0] addr, ill_q;
  wire [9:0] sel;
  wire [13:0] rs;
  wire access, ext_sec, sec_b, ill, ill_rst;
  wire [3:0] reg_q;
  integer seed = 93072, error_cnt = 0, check_count = 0, i, e_rst = 0, e_adr = 0, e_reg = 0;
  always #20 mclk = ~mclk;
  core_model core (.mclk(mclk), .req_addr(req_addr), .req_acc(req_acc), .addr(addr),
    .access(access));
  memory_map_address_decoder uut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
    .addr(addr), .access(access), .sel_io(sel[0]), .sel_ram(sel[1]), .sel_jump(sel[2]),
    .sel_routine(sel[3]), .sel_flash(sel[4]), .sel_sysreg(sel[5]), .sel_monitor(sel[6]),
    .sel_vector(sel[7]), .sel_reserved(sel[8]), .sel_unimp(sel[9]), .ext_security(ext_sec),
    .security_byte(sec_b), .system_break_status(rs[0]), .reset_cause_status(rs[1]),
    .break_flag_control(rs[2]), .irq_status_first(rs[3]), .irq_status_second(rs[4]),
    .irq_status_third(rs[5]), .flash_program_control(rs[6]), .breakpoint_addr_high(rs[7]),
    .breakpoint_addr_low(rs[8]), .breakpoint_control_status(rs[9]),
    .low_voltage_status(rs[10]), .flash_protect_boundary(rs[11]),
    .osc_trim_high_supply(rs[12]), .osc_trim_low_supply(rs[13]), .illegal_access(ill),
    .illegal_addr_rst_q(ill_rst), .illegal_addr_q(ill_q), .region_q(reg_q));
  function integer region(input integer a);
    if (a <= 16'h003F) region = 0;
    else if (a <= 16'h023F) region = 1;
    else if (a <= 16'h0FFF || (a >= 16'h1220 && a <= 16'h137D)) region = 9;
    else if (a <= 16'h101F) region = 2;
    else if (a <= 16'h13FF) region = 3;
    else if (a <= 16'hBFFF) region = 9;
    else if (a <= 16'hFDFF) region = 4;
    else if (a == 16'hFE02 || a == 16'hFE07 || (a >= 16'hFE0D && a <= 16'hFE1F)) region = 8;
    else if (a <= 16'hFE1F) region = 5;
    else if (a <= 16'hFF7D) region = 6;
    else if (a == 16'hFF7F || (a >= 16'hFF82 && a <= 16'hFFDB)) region = 9;
    else if (a <= 16'hFF81) region = 5;
    else region = 7;
  endfunction
  function integer ridx(input integer a);
    if (a == 16'hFE00 || a == 16'hFE01) ridx = a - 16'hFE00;
    else if (a >= 16'hFE03 && a <= 16'hFE06) ridx = a - 16'hFE01;
    else if (a >= 16'hFE08 && a <= 16'hFE0C) ridx = a - 16'hFE02;
    else if (a == 16'hFF7E) ridx = 11;
    else if (a == 16'hFF80 || a == 16'hFF81) ridx = a - 16'hFF74;
    else ridx = 14;
  endfunction
  function integer enc(input logic [9:0] s);
    enc = 15;
    for (int k = 0; k < 10; k++) if (s === (10'h001 << k)) enc = k;
  endfunction
  task check(input logic [79:0] name, input logic [15:0] exp, input logic [15:0] seen);
    check_count = check_count + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error %0s expected %h seen %h", name, exp, seen);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // outputs settle by the falling edge; model predicts state after the next rise
  always @(negedge mclk) begin
    if (run) begin
      check("region", region(addr), enc(sel));
      check("reg_sel", ridx(addr) < 14 ? 16'h0001 << ridx(addr) : 16'h0000, rs);
      check("security", {addr == 16'hFDFF, addr >= 16'hFFF6 && addr <= 16'hFFFD}, {ext_sec, sec_b});
      check("illegal", access && region(addr) == 9, ill);
      check("rst_q", e_rst, ill_rst);
      check("addr_q", e_adr, ill_q);
      check("region_q", e_reg, reg_q);
    end
    if (sys_rst) {e_rst, e_adr, e_reg} = 0;
    else if (clk_en) begin
      e_rst = access && region(addr) == 9;
      if (access) e_reg = region(addr);
      if (e_rst) e_adr = addr;
    end
  end
  initial begin
    #400000;
    error_cnt = error_cnt + 1;
    print_verdict;
  end
  initial begin
    edges = '{16'h0000, 16'h003F, 16'h0040, 16'h023F, 16'h0240, 16'h0FFF, 16'h1000, 16'h101F,
      16'h1020, 16'h121F, 16'h1220, 16'h137D, 16'h137E, 16'h13FF, 16'h1400, 16'hBFFF, 16'hC000};
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    run <= 1'b1;
    for (i = 0; i < 531; i = i + 1) begin
      @(posedge mclk);
      req_addr <= i < 514 ? 16'hFDFE + i : edges[i - 514];
      req_acc <= $random(seed);
    end
    $display("sweep test done");
    for (i = 0; i < 2000; i = i + 1) begin
      @(posedge mclk);
      req_addr <= $random(seed) | (i[0] ? 16'hFE00 : 16'h0000);
      req_acc <= $random(seed);
      clk_en <= i == 1000 || ($random(seed) & 3) != 0;
      sys_rst <= i == 1000;
    end
    @(posedge mclk);
    $display("random test done");
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
